// file: rtl/pss_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the source supervisor.
 Assumes a 125 MHz aclk; included by bare name.
*/
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// AXI4-Lite byte offsets
`define PSS_OFF_CTRL    8'h00
`define PSS_OFF_TARGET  8'h04
`define PSS_OFF_STATUS  8'h08
`define PSS_OFF_FAULT   8'h0c
`define PSS_OFF_OUTS    8'h10

// Control fields
`define PSS_CTRL_SLEW_LO   0
`define PSS_CTRL_COMP_LO   2
`define PSS_CTRL_ADV       4
`define PSS_CTRL_PROG      5
`define PSS_CTRL_HVSIG     6

// Reset values: slew code 3 = 83 mV/ms, comp code 2 = 100 mV/A, 3 A advertisement
`define PSS_SLEW_RST   2'h3
`define PSS_COMP_RST   2'h2
`define PSS_ADV_RST    1'h1
`define PSS_CTRL_RST   32'h0000_001b

// Supply target in 20 mV steps; 5.12 V = 256 steps, 5 V = 250 steps
`define PSS_TGT_DEF    10'h100
`define PSS_TGT_5V     10'h0fa

// Timing
`define PSS_CLK_MHZ        125
`define PSS_RESTORE_NS     80
`define PSS_RESTORE_CYC    ((`PSS_RESTORE_NS * `PSS_CLK_MHZ + 999) / 1000)

`endif

// file: rtl/pss_pkg.sv
/*
 Types of the source supervisor.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pss_pkg;

   typedef enum logic [3:0] {
      CC_UNATTACHED = 4'b0001,
      CC_ATTACH_WAIT = 4'b0010,
      CC_ATTACHED   = 4'b0100,
      CC_DETACHING  = 4'b1000
   } pss_cc_e;

   typedef enum logic [2:0] {
      DL_DIVIDER   = 3'b001,
      DL_DEDICATED = 3'b010,
      DL_HIGH_V    = 3'b100
   } pss_dl_e;

endpackage

// file: rtl/pss_sync.sv
/*
 Two-flop synchroniser for a vector of pin levels.
 Assumes inputs asynchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module pss_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule

`default_nettype wire

// file: rtl/pss_dline.sv
/*
 Data-line charging mode machine: divider, dedicated and high voltage modes.
 Assumes synchronised comparator inputs and a clear level held while unattached or while a fault is flagged.
*/
`timescale 1ns/1ps
`default_nettype none

module pss_dline (
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       restart,
   // Line comparators, synchronised
   input  wire logic       dp_below_sel,
   input  wire logic       dm_below_sel,
   input  wire logic       detect_done,
   // Controls
   output logic            line_src_en,
   output logic            line_short_resistor,
   output logic            high_voltage_charge_mode,
   output logic [1:0]      hv_sub_mode
);

   pss_pkg::pss_dl_e state;

   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         state <= pss_pkg::DL_DIVIDER;
      end else begin
         unique case (state)
            // R14 leave divider mode
            pss_pkg::DL_DIVIDER: begin
               if (dp_below_sel || dm_below_sel) begin
                  state <= pss_pkg::DL_DEDICATED;
               end
            end
            // R16 signal high voltage entry
            pss_pkg::DL_DEDICATED: begin
               if (detect_done) begin
                  state <= pss_pkg::DL_HIGH_V;
               end
            end
            pss_pkg::DL_HIGH_V: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         line_src_en              <= 1'b1;
         line_short_resistor      <= 1'b0;
         high_voltage_charge_mode <= 1'b0;
         hv_sub_mode              <= 2'h0;
      end else begin
         // R14 drive 2.7 V in divider
         line_src_en              <= (state == pss_pkg::DL_DIVIDER);
         // R15 short lines in dedicated
         line_short_resistor      <= (state == pss_pkg::DL_DEDICATED);
         high_voltage_charge_mode <= (state == pss_pkg::DL_HIGH_V);
         // R16 track line states
         hv_sub_mode              <= (state == pss_pkg::DL_HIGH_V) ?
                                     {dp_below_sel, dm_below_sel} : 2'h0;
      end
   end

   // R14 exit on pulled line
   a_divider_exit : assert property (@(posedge aclk) disable iff (!aresetn || restart) // R14
      state == pss_pkg::DL_DIVIDER && (dp_below_sel || dm_below_sel)
      |=> state == pss_pkg::DL_DEDICATED)
      else $error("divider mode not left");
   // R15 sources off when shorted
   a_short_exclusive : assert property (@(posedge aclk) disable iff (!aresetn) // R15
      !(line_src_en && line_short_resistor))
      else $error("line sources and short both on");

endmodule

`default_nettype wire

// file: rtl/pss_supervisor.sv
/*
 Digital supervision of a USB Type-C power source: attach, bleeders, slew and
 compensation selection, fault trips with auto restore, data-line charge modes.
 Assumes analog comparators on pins (synchronised here) and an AXI4-Lite master.
*/
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"

// Functional notes
// R1 - Four slew rates, 83 mV/ms after reset
// R2 - Compensation only at 5 V, no programmable offer
// R3 - Compensation slope 0/50/100/150, default 100
// R4 - Source-only terminations, 1.5 A or 3 A
// R5 - Route only active CC pin to signalling
// R6 - Attach only when bus inside vSafe0V
// R7 - Bus bleeder on detach or lowered contract
// R8 - Supply bleeder on detach or lowered target
// R9 - Supply over-voltage opens switch, auto restore
// R10 - Supply under-voltage opens switch, auto restore
// R11 - Over-current opens switch, auto restore
// R12 - Fast over-current opens switch at once
// R13 - Thermal trip restores below hysteresis point
// R14 - Divider mode exits when line pulled low
// R15 - Dedicated mode shorts lines, sources off
// R16 - Signal high voltage mode, track lines
// R17 - Current sense feeds three functions
// R18 - Unattached target is 5.12 V
// R19 - Thermal trip point is 140 C
// R20 - Per-source flags; restore before switch closes
module pss_supervisor (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address, data and response
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Comparator pins, asynchronous
   input  wire logic        cc1_sink_seen,
   input  wire logic        cc2_sink_seen,
   input  wire logic        vbus_safe0v,
   input  wire logic        vbus_at_target,
   input  wire logic        vin_at_target,
   input  wire logic        vin_over,
   input  wire logic        vin_under,
   input  wire logic        iout_over,
   input  wire logic        iout_fast_over,
   input  wire logic        temp_over_trip,
   input  wire logic        temp_below_hys,
   input  wire logic        dp_below_sel,
   input  wire logic        dm_below_sel,
   input  wire logic        detect_done,
   // Analog controls
   output logic             load_switch_on,
   output logic             cc_source_en,
   output logic             three_amp_advertisement,
   output logic             cc1_to_bmc,
   output logic             cc2_to_bmc,
   output logic             vbus_bleed_en,
   output logic             vin_bleed_en,
   output logic [1:0]       slew_sel,
   output logic [1:0]       comp_sel,
   output logic             comp_en,
   output logic [9:0]       vin_target,
   output logic             iout_cc_reg_en,
   output logic             line_src_en,
   output logic             line_short_resistor,
   output logic             high_voltage_charge_mode,
   output logic [1:0]       hv_sub_mode
);

   localparam int NS = 14;

   logic [NS-1:0]    pin_s;
   logic             cc1_s, cc2_s, safe0_s, vbus_ok_s, vin_ok_s;
   logic             ov_s, uv_s, oc_s, foc_s, tt_s, thys_s, dp_s, dm_s, done_s;
   logic [31:0]      ctrl;
   logic [9:0]       contract_target;
   logic [4:0]       fault;
   logic             any_fault, restart, restore_busy;
   logic [7:0]       restore_cnt;
   pss_pkg::pss_cc_e cc_state;
   logic             orient_cc2;
   logic             aw_held, w_held;
   logic [7:0]       aw_addr;
   logic [31:0]      w_data;
   logic [3:0]       w_strb;
   logic [31:0]      next_rdata;
   logic             vin_lowering, vbus_lowering;

   pss_sync #(.W(NS)) u_sync (
      .aclk   (aclk),
      .aresetn(aresetn),
      .din    ({cc1_sink_seen, cc2_sink_seen, vbus_safe0v, vbus_at_target, vin_at_target,
                vin_over, vin_under, iout_over, iout_fast_over, temp_over_trip,
                temp_below_hys, dp_below_sel, dm_below_sel, detect_done}),
      .dout   (pin_s)
   );
   assign {cc1_s, cc2_s, safe0_s, vbus_ok_s, vin_ok_s, ov_s, uv_s, oc_s, foc_s,
           tt_s, thys_s, dp_s, dm_s, done_s} = pin_s;

   // AXI4-Lite write: address and data taken in either order, then response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == `PSS_OFF_CTRL || aw_addr == `PSS_OFF_TARGET ||
                             aw_addr == `PSS_OFF_STATUS || aw_addr == `PSS_OFF_FAULT ||
                             aw_addr == `PSS_OFF_OUTS) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // Control register; a fault restore puts every setting back to its default
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         // R1 83 mV/ms default
         // R3 100 mV/A default
         // R4 3 A default
         ctrl            <= `PSS_CTRL_RST;
         contract_target <= `PSS_TGT_DEF;
      end else if (aw_held && w_held && !s_axi_bvalid) begin
         if (aw_addr == `PSS_OFF_CTRL) begin
            for (int b = 0; b < 4; b++) begin
               if (w_strb[b]) begin
                  ctrl[b*8 +: 8] <= w_data[b*8 +: 8] & (b == 0 ? 8'h7f : 8'h00);
               end
            end
         end else if (aw_addr == `PSS_OFF_TARGET && w_strb[0] && w_strb[1]) begin
            contract_target <= w_data[9:0];
         end
      end
   end

   // AXI4-Lite read
   always_comb begin
      unique case (s_axi_araddr)
         `PSS_OFF_CTRL:   next_rdata = ctrl;
         `PSS_OFF_TARGET: next_rdata = {22'h0, contract_target};
         `PSS_OFF_STATUS: next_rdata = {24'h0, cc_state, orient_cc2, restore_busy,
                                        load_switch_on, high_voltage_charge_mode};
         `PSS_OFF_FAULT:  next_rdata = {27'h0, fault};
         `PSS_OFF_OUTS:   next_rdata = {26'h0, vbus_bleed_en, vin_bleed_en, comp_en,
                                        hv_sub_mode, line_short_resistor};
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= (s_axi_araddr <= `PSS_OFF_OUTS && s_axi_araddr[1:0] == 2'h0)
                            ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // R20 per-source flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault <= 5'h00;
      end else begin
         // R9 over-voltage
         fault[0] <= ov_s;
         // R10 under-voltage, only once the supply is expected up
         fault[1] <= uv_s && cc_state == pss_pkg::CC_ATTACHED;
         // R11 R17 over-current
         fault[2] <= oc_s;
         // R12 R17 fast over-current
         fault[3] <= foc_s;
         // R13 R19 thermal trip with hysteresis
         if (tt_s) begin
            fault[4] <= 1'b1;
         end else if (thys_s) begin
            fault[4] <= 1'b0;
         end
      end
   end
   assign any_fault = |fault;

   // R20 restore defaults before reclosing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         restore_cnt  <= 8'h00;
         restore_busy <= 1'b0;
      end else if (any_fault) begin
         restore_cnt  <= 8'(`PSS_RESTORE_CYC);
         restore_busy <= 1'b1;
      end else if (restore_cnt != 8'h00) begin
         restore_cnt <= restore_cnt - 8'h01;
      end else begin
         restore_busy <= 1'b0;
      end
   end
   assign restart = any_fault;

   // Attach machine
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         cc_state   <= pss_pkg::CC_UNATTACHED;
         orient_cc2 <= 1'b0;
      end else begin
         unique case (cc_state)
            pss_pkg::CC_UNATTACHED: begin
               if (cc1_s || cc2_s) begin
                  cc_state   <= pss_pkg::CC_ATTACH_WAIT;
                  orient_cc2 <= cc2_s && !cc1_s;
               end
            end
            // R6 wait for vSafe0V
            pss_pkg::CC_ATTACH_WAIT: begin
               if (!(cc1_s || cc2_s)) begin
                  cc_state <= pss_pkg::CC_UNATTACHED;
               end else if (safe0_s) begin
                  cc_state <= pss_pkg::CC_ATTACHED;
               end
            end
            pss_pkg::CC_ATTACHED: begin
               if (!(orient_cc2 ? cc2_s : cc1_s)) begin
                  cc_state <= pss_pkg::CC_DETACHING;
               end
            end
            pss_pkg::CC_DETACHING: begin
               if (safe0_s) begin
                  cc_state <= pss_pkg::CC_UNATTACHED;
               end
            end
         endcase
      end
   end

   assign vin_lowering  = contract_target < vin_target;
   assign vbus_lowering = cc_state == pss_pkg::CC_ATTACHED && vin_lowering;

   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         vin_target    <= `PSS_TGT_DEF;
         vbus_bleed_en <= 1'b0;
         vin_bleed_en  <= 1'b0;
      end else begin
         // R18 5.12 V when unattached
         vin_target    <= (cc_state == pss_pkg::CC_ATTACHED) ? contract_target : `PSS_TGT_DEF;
         // R7 bus bleeder
         vbus_bleed_en <= (cc_state == pss_pkg::CC_DETACHING && !safe0_s) ||
                          (vbus_lowering && !vbus_ok_s);
         // R8 supply bleeder
         vin_bleed_en  <= (cc_state == pss_pkg::CC_DETACHING && !vin_ok_s) ||
                          (vin_lowering && !vin_ok_s);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_switch_on          <= 1'b0;
         cc_source_en            <= 1'b0;
         three_amp_advertisement <= `PSS_ADV_RST;
         cc1_to_bmc              <= 1'b0;
         cc2_to_bmc              <= 1'b0;
         slew_sel                <= `PSS_SLEW_RST;
         comp_sel                <= `PSS_COMP_RST;
         comp_en                 <= 1'b0;
         iout_cc_reg_en          <= 1'b0;
      end else begin
         // R20 switch closes only fault-free
         load_switch_on <= !any_fault && !restore_busy && cc_state == pss_pkg::CC_ATTACHED;
         // R4 source terminations only
         cc_source_en            <= 1'b1;
         three_amp_advertisement <= ctrl[`PSS_CTRL_ADV];
         // R5 one pin to signalling
         cc1_to_bmc <= cc_state == pss_pkg::CC_ATTACHED && !orient_cc2;
         cc2_to_bmc <= cc_state == pss_pkg::CC_ATTACHED && orient_cc2;
         // R1 slew select
         slew_sel <= ctrl[`PSS_CTRL_SLEW_LO +: 2];
         // R3 slope select
         comp_sel <= ctrl[`PSS_CTRL_COMP_LO +: 2];
         // R2 compensation gating
         comp_en  <= vin_target == `PSS_TGT_5V && !ctrl[`PSS_CTRL_PROG];
         // R17 constant-current loop
         iout_cc_reg_en <= cc_state == pss_pkg::CC_ATTACHED;
      end
   end

   pss_dline u_dline (
      .aclk                    (aclk),
      .aresetn                 (aresetn),
      .restart                 (restart || cc_state == pss_pkg::CC_UNATTACHED),
      .dp_below_sel            (dp_s),
      .dm_below_sel            (dm_s),
      .detect_done             (done_s),
      .line_src_en             (line_src_en),
      .line_short_resistor     (line_short_resistor),
      .high_voltage_charge_mode(high_voltage_charge_mode),
      .hv_sub_mode             (hv_sub_mode)
   );

   // R6 no attach without vSafe0V
   a_attach_safe0 : assert property (@(posedge aclk) disable iff (!aresetn || restart) // R6
      cc_state == pss_pkg::CC_ATTACH_WAIT && !safe0_s |=> cc_state != pss_pkg::CC_ATTACHED)
      else $error("attached without vSafe0V");
   // R5 exclusive routing
   a_bmc_onehot : assert property (@(posedge aclk) disable iff (!aresetn) // R5
      !(cc1_to_bmc && cc2_to_bmc))
      else $error("both CC pins routed");
   // R20 switch opens on fault
   a_switch_fault : assert property (@(posedge aclk) disable iff (!aresetn) // R20
      any_fault |=> !load_switch_on [*2])
      else $error("switch closed during fault");
   // R12 fast trip response
   a_fast_trip : assert property (@(posedge aclk) disable iff (!aresetn) // R12
      foc_s |=> fault[3] ##1 !load_switch_on)
      else $error("fast over-current slow");
   // R2 compensation off with programmable offer
   a_comp_prog : assert property (@(posedge aclk) disable iff (!aresetn) // R2
      $past(ctrl[`PSS_CTRL_PROG]) |-> !comp_en)
      else $error("compensation with programmable offer");
   // R13 thermal hold until hysteresis
   a_thermal_hold : assert property (@(posedge aclk) disable iff (!aresetn) // R13
      fault[4] && !tt_s && !thys_s |=> fault[4])
      else $error("thermal released early");
   // R18 default target
   a_default_tgt : assert property (@(posedge aclk) disable iff (!aresetn || restart) // R18
      cc_state == pss_pkg::CC_UNATTACHED |=> vin_target == `PSS_TGT_DEF)
      else $error("unattached target wrong");
   // R7 detach bleeder
   a_detach_bleed : assert property (@(posedge aclk) disable iff (!aresetn || restart) // R7
      cc_state == pss_pkg::CC_DETACHING && !safe0_s |=> vbus_bleed_en)
      else $error("bus bleeder off on detach");

endmodule

`default_nettype wire

// file: testbench/pss_sink_model.sv
/*
 Sink model: terminations, bus charge and data-line pulls.
 Assumes commands from the bench and the supervisor's controls.
*/
`timescale 1ns/1ps
`default_nettype none

module pss_sink_model (
   // Clock
   input  wire logic aclk,
   // Bench commands
   input  wire logic plug,
   input  wire logic flip,
   input  wire logic stale,
   input  wire logic pull_dp,
   input  wire logic finish,
   // Source controls
   input  wire logic cc_source_en,
   input  wire logic load_switch_on,
   input  wire logic vbus_bleed_en,
   input  wire logic line_short_resistor,
   // Sensed levels
   output logic      cc1_sink_seen,
   output logic      cc2_sink_seen,
   output logic      vbus_safe0v,
   output logic      dp_below_sel,
   output logic      dm_below_sel,
   output logic      detect_done
);
   logic [5:0] charge = 6'h00;

   assign cc1_sink_seen = plug & ~flip & cc_source_en;
   assign cc2_sink_seen = plug & flip & cc_source_en;
   always_ff @(posedge aclk) begin
      if (load_switch_on) begin
         charge <= 6'h3f;
      end else if (vbus_bleed_en) begin
         charge <= 6'h00;
      end else if (charge != 6'h00) begin
         charge <= charge - 6'h01;
      end
   end
   assign vbus_safe0v = (charge == 6'h00) & ~stale;
   assign dp_below_sel = pull_dp;
   assign dm_below_sel = pull_dp & line_short_resistor;
   assign detect_done = finish;
endmodule
`default_nettype wire

// file: testbench/tb_pss_supervisor.sv
/*
 Bench of the source supervisor: AXI4-Lite tasks, sink model, fault pins.
 Assumes registered handshakes and a 3-4 cycle pin latency.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pss_map.svh"

module tb_pss_supervisor;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, plug = 0, flip = 0, stale = 0, pull_dp = 0, finish = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, flt = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp, slew_sel, comp_sel, hv_sub_mode, seen;
   logic hot = 0, hys_ok = 1, at_tgt = 0, cc1_sink_seen, cc2_sink_seen, vbus_safe0v;
   logic dp_below_sel, dm_below_sel, detect_done, load_switch_on, cc_source_en, comp_en;
   logic three_amp_advertisement, cc1_to_bmc, cc2_to_bmc, vbus_bleed_en, vin_bleed_en;
   logic iout_cc_reg_en, line_src_en, line_short_resistor, high_voltage_charge_mode;
   logic [9:0] vin_target;
   int err_total = 0, checks_done = 0, cyc = 0;

   always #4 aclk = ~aclk;

   pss_sink_model pss_sink_model_i (.aclk, .plug, .flip, .stale, .pull_dp, .finish,
      .cc_source_en, .load_switch_on, .vbus_bleed_en, .line_short_resistor, .cc1_sink_seen,
      .cc2_sink_seen, .vbus_safe0v, .dp_below_sel, .dm_below_sel, .detect_done);

   pss_supervisor pss_supervisor_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cc1_sink_seen, .cc2_sink_seen,
      .vbus_safe0v, .vbus_at_target(at_tgt), .vin_at_target(at_tgt), .vin_over(flt[0]),
      .vin_under(flt[1]), .iout_over(flt[2]), .iout_fast_over(flt[3]), .temp_over_trip(hot),
      .temp_below_hys(hys_ok), .dp_below_sel, .dm_below_sel, .detect_done, .load_switch_on,
      .cc_source_en, .three_amp_advertisement, .cc1_to_bmc, .cc2_to_bmc, .vbus_bleed_en,
      .vin_bleed_en, .slew_sel, .comp_sel, .comp_en, .vin_target, .iout_cc_reg_en,
      .line_src_en, .line_short_resistor, .high_voltage_charge_mode, .hv_sub_mode);

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hang guard, well above the planned run
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      bit ad, wd;
      ad = 0;
      wd = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1;
            s_axi_awvalid <= 0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1;
            s_axi_wvalid <= 0;
         end
      end
      s_axi_bready <= 1;
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk({30'h0, s_axi_bresp}, {30'h0, r});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
   endtask

   initial begin
      tick(10);
      aresetn <= 1;
      tick(2);
      chk(slew_sel, 2'h3);
      chk(comp_sel, 2'h2);
      chk({cc_source_en, three_amp_advertisement}, 2'h3);
      chk(vin_target, 10'h100);
      chk(line_src_en, 1'h1);
      wr(8'hfc, 32'h0, 2'h2);
      rd(`PSS_OFF_CTRL, `PSS_CTRL_RST, 2'h0);
      rd(8'hfc, 32'h0, 2'h2);
      $display("test reset done");
      stale <= 1;
      plug <= 1;
      tick(20);
      chk(load_switch_on, 1'h0);
      stale <= 0;
      tick(30);
      chk({cc1_to_bmc, cc2_to_bmc, load_switch_on}, 3'h5);
      wr(`PSS_OFF_TARGET, 32'h0fa, 2'h0);
      wr(`PSS_OFF_CTRL, 32'h0c, 2'h0);
      tick(6);
      chk({slew_sel, comp_sel, three_amp_advertisement}, 5'h06);
      chk({vin_target, comp_en}, 11'h1f5);
      wr(`PSS_OFF_CTRL, 32'h2c, 2'h0);
      tick(6);
      chk(comp_en, 1'h0);
      $display("test attach and settings done");
      pull_dp <= 1;
      tick(8);
      chk({line_src_en, line_short_resistor}, 2'h1);
      finish <= 1;
      tick(8);
      chk(high_voltage_charge_mode, 1'h1);
      chk(hv_sub_mode, 2'h2);
      pull_dp <= 0;
      finish <= 0;
      tick(6);
      chk(hv_sub_mode, 2'h0);
      $display("test data lines done");
      for (int i = 0; i < 4; i++) begin
         flt[i] <= 1;
         tick(8);
         chk({load_switch_on, slew_sel}, 3'h3);
         flt <= 0;
         tick(120);
         chk(load_switch_on, 1'h1);
      end
      hot <= 1;
      hys_ok <= 0;
      tick(8);
      chk(load_switch_on, 1'h0);
      hot <= 0;
      tick(120);
      chk(load_switch_on, 1'h0);
      hys_ok <= 1;
      tick(120);
      chk(load_switch_on, 1'h1);
      $display("test faults done");
      plug <= 0;
      seen = 0;
      repeat (40) begin
         @(posedge aclk);
         seen = seen | {vbus_bleed_en, vin_bleed_en};
      end
      chk(seen, 2'h3);
      chk({vbus_bleed_en, vin_target}, 11'h100);
      plug <= 1;
      flip <= 1;
      tick(10);
      chk({cc1_to_bmc, cc2_to_bmc, load_switch_on, iout_cc_reg_en}, 4'h7);
      $display("test detach done");
      report_and_stop();
   end
endmodule
`default_nettype wire
